// ### logic/scrb_core.v
// Purpose: indexed configuration registers and the logic they steer
// Assumes: i_core_clk is the cpu double clock; I/O strobes are one-cycle pulses
// Notes: index is dropped after every data-port access
//
// Summary of operation
// RULE1 - recovery code 00..11 forces 3..6 bus clocks between I/O cycles
// RULE2 - bus clock is double clock divided by 10, 8, 6 or 4
// RULE3 - bit 3 enables slow refresh, bit 2 hidden refresh; both reset zero
// RULE4 - bits 7:6 of revision_and_expansion_bus_config read revision; writes ignored
// RULE5 - system control bit 7 enables byte swap for bus masters
// RULE6 - bit 6 set gives a latch pulse per cycle; clear gives one
// RULE7 - bit 5 clear: reset command waits for halt; set: reset at once
// RULE8 - bit 4 adds one wait state to standard bus cycles
// RULE9 - bit 1 clear: local ready synchronised, forwarded one state later
// RULE10 - bit 1 set: local ready not forwarded; local device drives cpu
// RULE11 - bit 0 zero enables memory parity checking, one disables it
// RULE12 - dram bits 7:6 give read wait states 0..3, reset 3
// RULE13 - dram bits 5:4 give write wait states 0..3, reset 3
// RULE14 - dram bits 3:0 encode bank sizes; two top codes reserved
// RULE15 - rom bit 7 also selects rom on writes for flash programming
// RULE16 - rom bits 6:0 enable 32KB segments C0000h..FFFFFh; bit 6 at reset
// RULE17 - software writes index to port 22h, then data via port 24h
// RULE18 - index invalidated after every data access
// RULE19 - reserved bits reset zero and software writes them zero
`timescale 1ns/1ns
`default_nettype none
`include "scrb_consts.vh"
module scrb_core #(
    parameter [1:0] REVISION = 2'b01 // arbitrary value
) (
    input wire i_core_clk,
    input wire i_rst_n,
    input wire [15:0] i_io_addr,
    input wire i_io_wr,
    input wire i_io_rd,
    input wire [7:0] i_io_wdata,
    output reg [7:0] o_io_rdata,
    input wire i_io_cycle_end,
    output reg o_io_recovery_busy,
    output reg o_expansion_bus_clock,
    output reg o_slow_refresh,
    output reg o_hidden_refresh,
    output reg o_master_byte_swap,
    output reg o_latch_each_cycle,
    output reg o_extra_wait,
    input wire i_reset_cmd,
    input wire i_halt_cycle,
    output reg o_cpu_reset,
    input wire i_local_ready_in_n,
    output reg o_cpu_ready_n,
    input wire i_parity_err,
    output reg o_parity_error,
    output reg [1:0] o_dram_read_waits,
    output reg [1:0] o_dram_write_waits,
    output reg [3:0] o_dram_bank_cfg,
    input wire [19:0] i_mem_addr,
    input wire i_mem_rd,
    input wire i_mem_wr,
    output reg o_rom_select_n
);
    reg [5:0] buscfg_q;
    reg [7:0] sysctl_q;
    reg [7:0] dramcfg_q;
    reg [7:0] romsel_q;
    reg [7:0] index_q;
    reg index_valid_q;
    reg [2:0] div_cnt_q;
    reg [2:0] rec_cnt_q;
    reg reset_pend_q;
    reg rdy_s1_q, rdy_s2_q, rdy_s3_q, rdy_q;
    // full 16-bit decode; aliases would let stray I/O hit the index
    wire idx_wr = i_io_wr && (i_io_addr == `SCRB_PORT_INDEX); // see RULE17
    wire data_acc = (i_io_wr || i_io_rd) && (i_io_addr == `SCRB_PORT_DATA);
    wire data_wr = i_io_wr && index_valid_q && (i_io_addr == `SCRB_PORT_DATA);
    wire [2:0] half_period = `SCRB_DIV_HALF_MAX - {1'b0, buscfg_q[1:0]}; // see RULE2
    wire bus_clk_rise = (div_cnt_q == 3'h1) && !o_expansion_bus_clock;
    // 32KB segments counted up from the rom base; the top 64KB shares bit 6
    wire [2:0] seg = i_mem_addr[17:15];
    wire in_rom = i_mem_addr[19:16] >= `SCRB_ROM_BASE; // C0000h..FFFFFh
    wire [2:0] seg_bit = (seg[2:1] == 2'b11) ? 3'h6 : seg;

    function [7:0] read_reg;
        input [7:0] idx;
        begin
            case (idx)
                `SCRB_IDX_BUSCFG: read_reg = {REVISION, buscfg_q}; // see RULE4
                `SCRB_IDX_SYSCTL: read_reg = sysctl_q;
                `SCRB_IDX_DRAMCFG: read_reg = dramcfg_q;
                `SCRB_IDX_ROMSEL: read_reg = romsel_q;
                // unmapped indices read like an idle bus
                default: read_reg = `SCRB_READ_UNMAPPED;
            endcase
        end
    endfunction

    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            buscfg_q <= `SCRB_RST_BUSCFG;
            sysctl_q <= `SCRB_RST_SYSCTL;
            dramcfg_q <= `SCRB_RST_DRAMCFG;
            romsel_q <= `SCRB_RST_ROMSEL; // see RULE16
            index_q <= 8'h00;
            index_valid_q <= 1'b0;
            o_io_rdata <= 8'h00;
        end else begin
            if (idx_wr) begin
                index_q <= i_io_wdata;
                index_valid_q <= 1'b1;
            end else if (data_acc) begin
                index_valid_q <= 1'b0; // see RULE18
            end
            if (i_io_rd && i_io_addr == `SCRB_PORT_DATA) begin
                o_io_rdata <= index_valid_q ? read_reg(index_q) : `SCRB_READ_UNMAPPED;
            end
            if (data_wr) begin
                case (index_q)
                    `SCRB_IDX_BUSCFG: buscfg_q <= i_io_wdata[5:0]; // see RULE4
                    // reserved bits 3:2 held at zero
                    `SCRB_IDX_SYSCTL: sysctl_q <= i_io_wdata & `SCRB_SYSCTL_WMASK; // see RULE19
                    `SCRB_IDX_DRAMCFG: dramcfg_q <= i_io_wdata;
                    `SCRB_IDX_ROMSEL: romsel_q <= i_io_wdata;
                    default: ;
                endcase
            end
        end
    end

    // bus clock divider; new ratio takes effect at next half-period boundary
    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            // start at the slowest ratio, matching the reset code
            div_cnt_q <= `SCRB_DIV_HALF_MAX;
            o_expansion_bus_clock <= 1'b0;
        end else if (div_cnt_q <= 3'h1) begin
            div_cnt_q <= half_period; // see RULE2
            o_expansion_bus_clock <= !o_expansion_bus_clock;
        end else begin
            div_cnt_q <= div_cnt_q - 3'h1;
        end
    end

    // recovery counted in whole bus clock rises after the cycle ends
    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            rec_cnt_q <= 3'h0;
            o_io_recovery_busy <= 1'b0;
        end else if (i_io_cycle_end) begin
            rec_cnt_q <= `SCRB_REC_BASE + {1'b0, buscfg_q[5:4]}; // see RULE1
            o_io_recovery_busy <= 1'b1;
        end else if (bus_clk_rise && rec_cnt_q != 3'h0) begin
            rec_cnt_q <= rec_cnt_q - 3'h1;
            o_io_recovery_busy <= rec_cnt_q != 3'h1;
        end
    end

    // reset command wait for halt unless fast mode
    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            reset_pend_q <= 1'b0;
            o_cpu_reset <= 1'b0;
        end else begin
            o_cpu_reset <= 1'b0;
            if (i_reset_cmd && sysctl_q[5]) begin
                o_cpu_reset <= 1'b1; // see RULE7
            end else if (reset_pend_q && i_halt_cycle) begin
                o_cpu_reset <= 1'b1; // see RULE7
                // a command arriving with the halt stays pending, not lost
                reset_pend_q <= i_reset_cmd;
            end else if (i_reset_cmd) begin
                reset_pend_q <= 1'b1;
            end
        end
    end

    // ready sync: second and third stage must agree before a change counts
    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            rdy_s1_q <= 1'b1;
            rdy_s2_q <= 1'b1;
            rdy_s3_q <= 1'b1;
            rdy_q <= 1'b1;
            o_cpu_ready_n <= 1'b1;
        end else begin
            rdy_s1_q <= i_local_ready_in_n;
            rdy_s2_q <= rdy_s1_q;
            rdy_s3_q <= rdy_s2_q;
            if (rdy_s2_q == rdy_s3_q) begin
                rdy_q <= rdy_s3_q;
            end
            // local device drives the cpu itself in direct mode
            o_cpu_ready_n <= sysctl_q[1] ? 1'b1 : rdy_q; // see RULE9 see RULE10
        end
    end

    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_slow_refresh <= 1'b0;
            o_hidden_refresh <= 1'b0;
            o_master_byte_swap <= 1'b0;
            o_latch_each_cycle <= 1'b1;
            o_extra_wait <= 1'b0;
            o_parity_error <= 1'b0;
            o_dram_read_waits <= 2'h3;
            o_dram_write_waits <= 2'h3;
            o_dram_bank_cfg <= 4'h0;
            o_rom_select_n <= 1'b1;
        end else begin
            // every pin re-registered; costs one cycle after a write
            o_slow_refresh <= buscfg_q[3]; // see RULE3
            o_hidden_refresh <= buscfg_q[2]; // see RULE3
            o_master_byte_swap <= sysctl_q[7]; // see RULE5
            o_latch_each_cycle <= sysctl_q[6]; // see RULE6
            o_extra_wait <= sysctl_q[4]; // see RULE8
            o_parity_error <= i_parity_err && !sysctl_q[0]; // see RULE11
            o_dram_read_waits <= dramcfg_q[7:6]; // see RULE12
            o_dram_write_waits <= dramcfg_q[5:4]; // see RULE13
            o_dram_bank_cfg <= dramcfg_q[3:0]; // see RULE14
            o_rom_select_n <= !(in_rom && romsel_q[seg_bit]
                && (i_mem_rd || (i_mem_wr && romsel_q[7]))); // see RULE15 see RULE16
        end
    end
endmodule // scrb_core
`default_nettype wire

// ### logic/scrb_consts.vh
// Purpose: constants for the system configuration register bank
// Assumes: included by scrb_core.v only
// Notes: offsets are I/O ports and register indices
`ifndef SCRB_CONSTS_VH
`define SCRB_CONSTS_VH
`define SCRB_PORT_INDEX 16'h0022
`define SCRB_PORT_DATA 16'h0024
`define SCRB_IDX_BUSCFG 8'h20
`define SCRB_IDX_SYSCTL 8'h21
`define SCRB_IDX_DRAMCFG 8'h22
`define SCRB_IDX_ROMSEL 8'h23
`define SCRB_RST_BUSCFG 6'h00
`define SCRB_RST_SYSCTL 8'h40
`define SCRB_RST_DRAMCFG 8'hF0
`define SCRB_RST_ROMSEL 8'h40
`define SCRB_SYSCTL_WMASK 8'hF3
`define SCRB_READ_UNMAPPED 8'hFF
`define SCRB_REC_BASE 3'h3
`define SCRB_DIV_HALF_MAX 3'h5
`define SCRB_ROM_BASE 4'hC
`endif

// ### dv/scrb_core_checker.sv
// Purpose: port checks for scrb_core
// Assumes: sync active-low reset
// Notes: attached by bind below
`timescale 1ns/1ns
`default_nettype none
module scrb_core_checker (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_io_wr,
    input wire logic i_io_cycle_end,
    input wire logic [15:0] i_io_addr,
    input wire logic o_io_recovery_busy,
    input wire logic o_expansion_bus_clock,
    input wire logic o_cpu_reset,
    input wire logic i_reset_cmd,
    input wire logic i_halt_cycle,
    input wire logic i_local_ready_in_n,
    input wire logic o_cpu_ready_n,
    input wire logic i_parity_err,
    input wire logic o_parity_error,
    input wire logic o_slow_refresh,
    input wire logic o_hidden_refresh,
    input wire logic [19:0] i_mem_addr,
    input wire logic i_mem_rd,
    input wire logic i_mem_wr,
    input wire logic o_rom_select_n
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    wire dwr = i_io_wr && i_io_addr == 16'h0024;
    sequence busy_hold; o_io_recovery_busy [*8]; endsequence
    sequence bclk_gap;
        $stable(o_expansion_bus_clock) ##[1:4] $changed(o_expansion_bus_clock);
    endsequence
    AST_REC_START: assert property (i_io_cycle_end |=> busy_hold)
        else $error("recovery too short");
    AST_REC_END: assert property (
        $rose(o_io_recovery_busy) |-> ##[1:72] !o_io_recovery_busy)
        else $error("recovery too long");
    AST_BCLK: assert property ($changed(o_expansion_bus_clock) |=> bclk_gap)
        else $error("bus clock half period");
    AST_CPURST: assert property (
        $rose(o_cpu_reset) |-> $past(i_reset_cmd) || $past(i_halt_cycle))
        else $error("cpu reset without cause");
    AST_PARITY: assert property (o_parity_error |-> $past(i_parity_err))
        else $error("parity error without cause");
    AST_READY: assert property (i_local_ready_in_n [*7] |-> o_cpu_ready_n)
        else $error("ready without local ready");
    AST_ROM_OUT: assert property (
        (i_mem_rd || i_mem_wr) && i_mem_addr[19:18] != 2'h3 |=> o_rom_select_n)
        else $error("rom select outside rom area");
    AST_CFG: assert property (
        $changed({o_slow_refresh, o_hidden_refresh}) |-> $past(dwr, 2))
        else $error("refresh mode changed without write");
endmodule // scrb_core_checker
bind scrb_core scrb_core_checker u_chk (.*);
`default_nettype wire

// ### dv/testbench.sv
// Purpose: self-checking bench for scrb_core
// Assumes: default revision parameter 01
// Notes: m[] mirrors the registers as software reads them
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic i_core_clk = 0, i_rst_n = 0, i_io_wr = 0, i_io_rd = 0, i_io_cycle_end = 0;
    logic i_reset_cmd = 0, i_halt_cycle = 0, i_local_ready_in_n = 1, i_parity_err = 0;
    logic i_mem_rd = 0, i_mem_wr = 0, o_io_recovery_busy, o_expansion_bus_clock, o_cpu_reset;
    logic o_slow_refresh, o_hidden_refresh, o_master_byte_swap, o_latch_each_cycle;
    logic o_extra_wait, o_cpu_ready_n, o_parity_error, o_rom_select_n;
    logic [15:0] i_io_addr = 0;
    logic [7:0] i_io_wdata = 0, o_io_rdata;
    logic [19:0] i_mem_addr = 0;
    logic [1:0] o_dram_read_waits, o_dram_write_waits;
    logic [3:0] o_dram_bank_cfg;
    int bad_count = 0, n_compared = 0, cyc = 0, nrst = 0, n, v, h;
    int m[4] = '{8'h40, 8'h40, 8'hF0, 8'h40};
    wire [12:0] cfg = {o_slow_refresh, o_hidden_refresh, o_master_byte_swap,
        o_latch_each_cycle, o_extra_wait, o_dram_read_waits, o_dram_write_waits, o_dram_bank_cfg};
    always #5 i_core_clk = ~i_core_clk;
    scrb_core u_dut (.*);
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge i_core_clk) begin
        if (o_cpu_reset === 1'h1) nrst++;
        cyc++;
        if (cyc == 30000) begin
            bad_count++;
            report_and_stop();
        end
    end
    task automatic chk(string s, logic [15:0] seen, logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s exp %h seen %h", s, exp, seen);
        end
    endtask
    task automatic io(logic w, logic [15:0] a, int d);
        @(posedge i_core_clk) {i_io_wr, i_io_rd, i_io_addr, i_io_wdata} <= {w, !w, a, d[7:0]};
        @(posedge i_core_clk) {i_io_wr, i_io_rd} <= 2'h0;
    endtask
    task automatic dread(int e);
        io(0, 16'h0024, 0);
        @(negedge i_core_clk);
        chk("rdata", o_io_rdata, e[7:0]);
    endtask
    task automatic rreg(int i, int e);
        io(1, 16'h0022, i);
        dread(e);
    endtask
    task automatic wreg(int i, int d);
        io(1, 16'h0022, i);
        io(1, 16'h0024, d);
        m[i - 32] = i == 32 ? 8'h40 | d & 8'h3F : i == 33 ? d & 8'hF3 : d & 8'hFF;
        repeat (3) @(posedge i_core_clk);
    endtask
    task automatic mem(logic w, int a, logic e);
        @(posedge i_core_clk) {i_mem_wr, i_mem_rd, i_mem_addr} <= {w, !w, a[19:0]};
        // select is registered: it answers one edge after the cycle is seen
        @(posedge i_core_clk);
        @(negedge i_core_clk);
        chk("rom_sel", o_rom_select_n, e);
        @(posedge i_core_clk) {i_mem_wr, i_mem_rd} <= 2'h0;
    endtask
    initial begin
        v = $urandom(32'hB53F);
        repeat (2) @(posedge i_core_clk);
        i_rst_n <= 1'h1;
        for (n = 0; n < 7; n++) begin
            for (int i = 0; i < 4; i++) rreg(32 + i, m[i]);
            chk("cfg_hi", cfg[12:8], {m[0][3:2], m[1][7:6], m[1][4]});
            chk("cfg_lo", cfg[7:0], m[2][7:0]);
            // reserved control bits and the two top bank codes are never written
            for (int i = 0; i < 4; i++)
                wreg(32 + i, $urandom & (i == 1 ? 8'hF3 : i == 2 ? 8'hFD : 8'hFF));
        end
        dread(8'hFF);
        io(1, 16'h0024, 0);
        rreg(35, m[3]);
        rreg(48, 8'hFF);
        for (n = 0; n < 7; n++) begin
            wreg(35, n % 2 << 7 | 1 << n);
            mem(0, 20'hC0000 + n * 20'h08000, 0);
            mem(1, 20'hC0000 + n * 20'h08000, n % 2 == 0);
            mem(0, 20'hC0000 + (n + 1) % 7 * 20'h08000, 1);
        end
        mem(0, 20'h80000, 1);
        mem(0, 20'hF8000, 0);
        for (n = 0; n < 2; n++) begin
            wreg(33, 8'h40 | n << 5);
            h = nrst;
            @(posedge i_core_clk) i_reset_cmd <= 1'h1;
            @(posedge i_core_clk) i_reset_cmd <= 1'h0;
            repeat (6) @(posedge i_core_clk);
            chk("cpu_reset", nrst - h, n);
            @(posedge i_core_clk) i_halt_cycle <= 1'h1;
            @(posedge i_core_clk) i_halt_cycle <= 1'h0;
            repeat (3) @(posedge i_core_clk);
            chk("cpu_reset", nrst - h, 1);
            @(posedge i_core_clk) {i_local_ready_in_n, i_parity_err} <= 2'h1;
            repeat (8) @(posedge i_core_clk);
            wreg(33, 8'h40 | n * 3);
            chk("rdy_par", {o_cpu_ready_n, o_parity_error}, n ? 2 : 1);
            @(posedge i_core_clk) {i_local_ready_in_n, i_parity_err} <= 2'h2;
            repeat (8) @(posedge i_core_clk);
            chk("rdy_par", {o_cpu_ready_n, o_parity_error}, 2);
        end
        for (n = 0; n < 4; n++) begin
            wreg(32, n << 4 | n);
            repeat (2) @(posedge o_expansion_bus_clock);
            for (v = 0; o_expansion_bus_clock; v++) @(negedge i_core_clk);
            chk("half_period", v, 6 - n);
            @(posedge i_core_clk) i_io_cycle_end <= 1'h1;
            @(posedge i_core_clk) i_io_cycle_end <= 1'h0;
            @(negedge i_core_clk);
            for (v = 0; o_io_recovery_busy; v++) @(negedge i_core_clk);
            h = 10 - 2 * n;
            chk("recovery", v >= (2 + n) * h - 1 && v <= (3 + n) * h + 1, 1);
        end
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
